// *** src/two_hand_pkg.sv ***
// ============================================================
// Shared constants for the two-hand control logic
package two_hand_pkg;

  // ============================================================
  // Clock and times
  localparam int CLK_HZ         = 125_000_000;
  localparam int CYC_PER_MS     = CLK_HZ / 1000;
  localparam int CYC_PER_US     = CLK_HZ / 1_000_000;
  localparam int SYNC_WINDOW_MS = 500;
  localparam int REACT_MS       = 20;
  localparam int TEST_HALF_US   = 1000;
  localparam int DEBOUNCE_US    = 5000;

  // Longest times, rounded down
  localparam int SYNC_WINDOW_CYC = CYC_PER_MS * SYNC_WINDOW_MS;
  localparam int REACT_CYC       = CYC_PER_MS * REACT_MS;
  // Least times, rounded up
  localparam int TEST_HALF_CYC   = CYC_PER_US * TEST_HALF_US;
  localparam int DEBOUNCE_CYC    = CYC_PER_US * DEBOUNCE_US;
  localparam int RET_FILTER_CYC  = 4;

  // ============================================================
  // Widths and line indices
  localparam int CNT_W     = 26;
  localparam int FLT_W     = 24;
  localparam int NUM_RET   = 4;
  localparam int RET_L_NO  = 0;
  localparam int RET_L_NC  = 1;
  localparam int RET_R_NO  = 2;
  localparam int RET_R_NC  = 3;
  localparam logic LVL_LOW = 1'b0;

  // ============================================================
  // Control states
  typedef enum logic [2:0] {
    ST_WAIT_RELEASE,
    ST_IDLE,
    ST_ONE_PRESSED,
    ST_ON,
    ST_FAULT
  } state_t;

  // Closed contact means pressed for a make contact, released for a break contact
  function automatic logic contact_pressed(input logic closed, input logic nc);
    contact_pressed = nc ? !closed : closed;
  endfunction : contact_pressed

endpackage : two_hand_pkg

// *** src/input_filter.sv ***
`timescale 1ns/10ps
// ============================================================
// Two-stage synchroniser followed by a stability filter
module input_filter
  import two_hand_pkg::*;
#(
  parameter int   STABLE_CYC  = RET_FILTER_CYC,
  parameter logic RESET_LEVEL = LVL_LOW
) (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic raw_i,
  output logic      level_o
);

  logic             meta_r;
  logic             sync_r;
  logic             level_r;
  logic [FLT_W-1:0] stable_cnt_r;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= RESET_LEVEL;
      sync_r <= RESET_LEVEL;
    end
    else
    begin
      meta_r <= raw_i;
      sync_r <= meta_r;
    end
  end

  // bounce filter
  // A level is accepted only after it has held unchanged for the full count
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stable_cnt_r <= '0;
      level_r      <= RESET_LEVEL;
    end
    else if (sync_r == level_r)
    begin
      stable_cnt_r <= '0;
    end
    else if (stable_cnt_r == FLT_W'(STABLE_CYC - 1))
    begin
      stable_cnt_r <= '0;
      level_r      <= sync_r;
    end
    else
    begin
      stable_cnt_r <= stable_cnt_r + 1'b1;
    end
  end

  assign level_o = level_r;

endmodule : input_filter

// *** src/two_hand_control.sv ***
`timescale 1ns/10ps
// Function
// - Energize only if both pressed within window
// - Ready only while feedback loop closed
// - Accept request only with outputs de-energized
// - Single button held keeps outputs off
// - Second press after window keeps outputs off
// - Open feedback loop inhibits activation
// - Detected faults inhibit activation
// - Any button release drops outputs at once
// - Re-arm needs both released, loop closed
// - Cyclic self-test finds faults before actuation
// - Output contacts checked against commanded state
// - Control line shorts block the outputs
// - Two redundant outputs switch together
// - Each button make or break contact
// - Outputs drop within twenty milliseconds
// - Outputs rise within twenty milliseconds
module two_hand_control
  import two_hand_pkg::*;
#(
  parameter int SYNC_WIN_CYC = two_hand_pkg::SYNC_WINDOW_CYC,
  parameter int REACT_LIM    = two_hand_pkg::REACT_CYC,
  parameter int TEST_HALF    = two_hand_pkg::TEST_HALF_CYC,
  parameter int DEBOUNCE     = two_hand_pkg::DEBOUNCE_CYC
) (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic left_button_nc_i,
  input  wire logic right_button_nc_i,
  output logic      left_button_line_a_o,
  input  wire logic left_button_line_b_i,
  input  wire logic left_button_line_c_i,
  output logic      right_button_line_a_o,
  input  wire logic right_button_line_b_i,
  input  wire logic right_button_line_c_i,
  input  wire logic feedback_loop_i,
  input  wire logic contactor_mirror_a_i,
  input  wire logic contactor_mirror_b_i,
  output logic      safety_out_a_o,
  output logic      safety_out_b_o,
  output logic      ready_o,
  output logic      fault_o
);
  import two_hand_pkg::*;

  // ============================================================
  // Input conditioning
  logic [NUM_RET-1:0] ret_raw;
  logic [NUM_RET-1:0] ret;
  logic               fb_closed;
  logic               mir_a;
  logic               mir_b;

  assign ret_raw = {right_button_line_c_i, right_button_line_b_i,
                    left_button_line_c_i, left_button_line_b_i};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_RET; gi++)
    begin : g_ret
      input_filter #(.STABLE_CYC(RET_FILTER_CYC), .RESET_LEVEL(LVL_LOW)) u_ret (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .raw_i   (ret_raw[gi]),
        .level_o (ret[gi])
      );
    end
  endgenerate

  input_filter #(.STABLE_CYC(DEBOUNCE), .RESET_LEVEL(LVL_LOW)) u_fb (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .raw_i   (feedback_loop_i),
    .level_o (fb_closed)
  );
  input_filter #(.STABLE_CYC(DEBOUNCE), .RESET_LEVEL(LVL_LOW)) u_mir_a (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .raw_i   (contactor_mirror_a_i),
    .level_o (mir_a)
  );
  input_filter #(.STABLE_CYC(DEBOUNCE), .RESET_LEVEL(LVL_LOW)) u_mir_b (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .raw_i   (contactor_mirror_b_i),
    .level_o (mir_b)
  );

  // ============================================================
  // Contact type straps, caught once after reset release
  logic mode_done_r;
  logic nc_l_r;
  logic nc_r_r;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_done_r <= 1'b0;
      nc_l_r      <= 1'b0;
      nc_r_r      <= 1'b0;
    end
    else if (!mode_done_r)
    begin
      mode_done_r <= 1'b1;
      nc_l_r      <= left_button_nc_i;
      nc_r_r      <= right_button_nc_i;
    end
  end

  // ============================================================
  // Test pattern on the button lines
  logic [CNT_W-1:0]   test_cnt_r;
  logic               drive_r;
  logic               phase_end;
  logic [NUM_RET-1:0] hi_r;
  logic               short_det_r;
  logic               eval_l;
  logic               eval_r;
  logic               prev_l_r;
  logic               prev_r_r;
  logic               pressed_l_r;
  logic               pressed_r_r;
  logic [1:0]         seen_cnt_r;
  logic               inputs_seen;

  localparam logic [1:0] EVALS_TO_TRUST = 2'h3;

  assign phase_end = (test_cnt_r == CNT_W'(TEST_HALF - 1));

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      test_cnt_r <= '0;
      drive_r    <= 1'b0;
    end
    else if (phase_end)
    begin
      test_cnt_r <= '0;
      drive_r    <= !drive_r;
    end
    else
    begin
      test_cnt_r <= test_cnt_r + 1'b1;
    end
  end

  assign left_button_line_a_o  = drive_r;
  assign right_button_line_a_o = drive_r;

  // A closed contact echoes the test level in both phases of the cycle
  assign eval_l = contact_pressed(nc_l_r ? hi_r[RET_L_NC] : hi_r[RET_L_NO], nc_l_r);
  assign eval_r = contact_pressed(nc_r_r ? hi_r[RET_R_NC] : hi_r[RET_R_NO], nc_r_r);

  // short detection
  // A return high while undriven is a short; the unused line must stay dead
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hi_r        <= '0;
      short_det_r <= 1'b0;
    end
    else
    begin
      short_det_r <= 1'b0;
      if (phase_end && drive_r)
      begin
        hi_r        <= ret;
        short_det_r <= (nc_l_r ? ret[RET_L_NO] : ret[RET_L_NC])
                     | (nc_r_r ? ret[RET_R_NO] : ret[RET_R_NC]);
      end
      else if (phase_end && !drive_r)
      begin
        short_det_r <= |ret;
      end
    end
  end

  // button debounce
  // Two matching test cycles are needed, so bounce cannot open the window
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prev_l_r    <= 1'b0;
      prev_r_r    <= 1'b0;
      pressed_l_r <= 1'b0;
      pressed_r_r <= 1'b0;
    end
    else if (phase_end && !drive_r && mode_done_r)
    begin
      prev_l_r <= eval_l;
      prev_r_r <= eval_r;
      if (eval_l == prev_l_r)
      begin
        pressed_l_r <= eval_l;
      end
      if (eval_r == prev_r_r)
      begin
        pressed_r_r <= eval_r;
      end
    end
  end

  // trust after three evaluations
  // The first evaluation sees reset levels and the second has no real predecessor
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      seen_cnt_r <= '0;
    end
    else if (phase_end && !drive_r && mode_done_r && !inputs_seen)
    begin
      seen_cnt_r <= seen_cnt_r + 1'b1;
    end
  end

  assign inputs_seen = (seen_cnt_r == EVALS_TO_TRUST);

  // ============================================================
  // Output contact monitoring and fault latch
  logic             out_r;
  logic             out_b_r;
  logic [CNT_W-1:0] mism_cnt_r;
  logic             mism;
  logic             mirror_fault;
  logic             fault_r;

  assign mism         = (mir_a != out_r) || (mir_b != out_r);
  assign mirror_fault = (mism_cnt_r == CNT_W'(REACT_LIM + DEBOUNCE));

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mism_cnt_r <= '0;
    end
    else if (!mism)
    begin
      mism_cnt_r <= '0;
    end
    else if (!mirror_fault)
    begin
      mism_cnt_r <= mism_cnt_r + 1'b1;
    end
  end

  // sticky fault
  // Cleared only by reset, so a single fault can never be masked later
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      fault_r <= 1'b0;
    end
    else if (short_det_r || mirror_fault)
    begin
      fault_r <= 1'b1;
    end
  end

  // ============================================================
  // Two-hand sequence
  state_t           state_r;
  state_t           state_nxt;
  logic [CNT_W-1:0] win_cnt_r;
  logic             both_pressed;
  logic             any_pressed;
  logic             win_open;
  logic             can_start;

  assign both_pressed = pressed_l_r && pressed_r_r;
  assign any_pressed  = pressed_l_r || pressed_r_r;
  assign win_open     = (win_cnt_r < CNT_W'(SYNC_WIN_CYC));
  assign can_start    = fb_closed && !mir_a && !mir_b && !fault_r;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_WAIT_RELEASE:
        if (fault_r)
          state_nxt = ST_FAULT;
        else if (mode_done_r && inputs_seen && !any_pressed && fb_closed)
          state_nxt = ST_IDLE;
      ST_IDLE:
        if (fault_r)
          state_nxt = ST_FAULT;
        else if (any_pressed && !can_start)
          state_nxt = ST_WAIT_RELEASE;
        else if (both_pressed)
          state_nxt = ST_ON;
        else if (any_pressed)
          state_nxt = ST_ONE_PRESSED;
      ST_ONE_PRESSED:
        if (fault_r)
          state_nxt = ST_FAULT;
        else if (!any_pressed || !win_open || !can_start)
          state_nxt = ST_WAIT_RELEASE;
        else if (both_pressed)
          state_nxt = ST_ON;
      ST_ON:
        if (fault_r)
          state_nxt = ST_FAULT;
        else if (!both_pressed)
          state_nxt = ST_WAIT_RELEASE;
      ST_FAULT:
        state_nxt = ST_FAULT;
      default:
        state_nxt = ST_FAULT;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= ST_WAIT_RELEASE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      win_cnt_r <= '0;
    end
    else if (state_r == ST_ONE_PRESSED && win_open)
    begin
      win_cnt_r <= win_cnt_r + 1'b1;
    end
    else if (state_r != ST_ONE_PRESSED)
    begin
      win_cnt_r <= '0;
    end
  end

  // rise on next edge
  // Two flops from one decision; the readback catches a stuck relay
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      out_r   <= 1'b0;
      out_b_r <= 1'b0;
    end
    else
    begin
      out_r   <= (state_nxt == ST_ON);
      out_b_r <= (state_nxt == ST_ON);
    end
  end

  assign safety_out_a_o = out_r;
  assign safety_out_b_o = out_b_r;
  assign ready_o        = (state_r == ST_IDLE) && can_start;
  assign fault_o        = fault_r;

  // ============================================================
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_outputs_equal: assert property (out_r == out_b_r)
    else $error("safety outputs differ");
  a_release_drops: assert property (out_r && !both_pressed |=> !out_r)
    else $error("outputs held after release");
  a_single_off: assert property (out_r |-> $past(pressed_l_r && pressed_r_r))
    else $error("output on without both buttons");
  a_feedback_gate: assert property ($rose(out_r) |-> $past(fb_closed))
    else $error("output rose with open loop");
  a_fault_blocks: assert property (fault_r |=> !out_r)
    else $error("output on during fault");
  a_window_bound: assert property ($rose(out_r) |-> $past(win_open))
    else $error("output rose after window");
  a_request_off: assert property ($rose(out_r) |-> $past(!mir_a && !mir_b))
    else $error("request accepted with contacts on");
  a_rearm_needed: assert property (
    $past(state_r) == ST_WAIT_RELEASE && state_r == ST_IDLE
    |-> $past(!any_pressed && fb_closed))
    else $error("re-armed without release");
  a_mirror_fault: assert property (mirror_fault |=> fault_r)
    else $error("contact mismatch not latched");
  a_short_fault: assert property (short_det_r |=> fault_r ##1 !out_r)
    else $error("line short not latched");
  a_energize_fast: assert property (
    state_r == ST_ONE_PRESSED && both_pressed && win_open && can_start |=> out_r)
    else $error("valid actuation not energized");

endmodule : two_hand_control

// *** sim/button_contactor_model.sv ***
`timescale 1ns/10ps
// ============================================================
// Two push-buttons and a downstream contactor pair
module button_contactor_model (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic left_press_i,
  input  wire logic right_press_i,
  input  wire logic left_nc_i,
  input  wire logic right_nc_i,
  input  wire logic left_short_i,
  input  wire logic right_short_i,
  input  wire logic loop_open_i,
  input  wire logic mirror_stuck_i,
  input  wire logic left_button_line_a_i,
  input  wire logic right_button_line_a_i,
  input  wire logic safety_out_a_i,
  input  wire logic safety_out_b_i,
  output logic      left_button_line_b_o,
  output logic      left_button_line_c_o,
  output logic      right_button_line_b_o,
  output logic      right_button_line_c_o,
  output logic      feedback_loop_o,
  output logic      contactor_mirror_a_o,
  output logic      contactor_mirror_b_o
);
  logic mirror_a_r;
  logic mirror_b_r;

  // ============================================================
  // Buttons: a closed contact echoes the test drive, an open one is pulled low
  // A short ties the make-contact return to the supply, so it reads high in both phases
  assign left_button_line_b_o  = left_short_i | (!left_nc_i & left_press_i & left_button_line_a_i);
  assign left_button_line_c_o  = left_nc_i & !left_press_i & left_button_line_a_i;
  assign right_button_line_b_o = right_short_i
                               | (!right_nc_i & right_press_i & right_button_line_a_i);
  assign right_button_line_c_o = right_nc_i & !right_press_i & right_button_line_a_i;

  // ============================================================
  // Contactors follow the outputs one cycle late; a welded contact stays closed
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mirror_a_r <= 1'b0;
      mirror_b_r <= 1'b0;
    end
    else
    begin
      mirror_a_r <= safety_out_a_i | mirror_stuck_i;
      mirror_b_r <= safety_out_b_i | mirror_stuck_i;
    end
  end
  assign contactor_mirror_a_o = mirror_a_r;
  assign contactor_mirror_b_o = mirror_b_r;

  assign feedback_loop_o = !loop_open_i & !mirror_a_r & !mirror_b_r;
endmodule : button_contactor_model

// *** sim/two_hand_control_logic_test.sv ***
`timescale 1ns/10ps
// ============================================================
// Self-checking bench for the two-hand control logic
module two_hand_control_logic_test;
  import two_hand_pkg::*;

  typedef struct {logic l_nc; logic r_nc; logic both; int gap; logic on;} row_t;

  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic l_press = 1'b0, r_press = 1'b0, l_nc = 1'b0, r_nc = 1'b0;
  logic l_short = 1'b0, r_short = 1'b0, loop_open = 1'b0, stuck = 1'b0;
  logic la, ra, lb, lc, rb, rc, fb, ma, mb, out_a, out_b, ready, fault;
  int   error_cnt = 0;
  int   checks = 0;
  // Gap 600 outlasts the 400-cycle window even with detection jitter
  row_t rows [6] = '{'{0, 0, 1, 0, 1}, '{1, 0, 1, 100, 1}, '{0, 1, 1, 100, 1},
                     '{1, 1, 1, 0, 1}, '{0, 0, 1, 600, 0}, '{1, 1, 0, 600, 0}};

  always #4 mclk_i = ~mclk_i;

  two_hand_control #(.SYNC_WIN_CYC(400), .REACT_LIM(200), .TEST_HALF(16), .DEBOUNCE(8)) u_dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .left_button_nc_i(l_nc), .right_button_nc_i(r_nc),
    .left_button_line_a_o(la), .left_button_line_b_i(lb), .left_button_line_c_i(lc),
    .right_button_line_a_o(ra), .right_button_line_b_i(rb), .right_button_line_c_i(rc),
    .feedback_loop_i(fb), .contactor_mirror_a_i(ma), .contactor_mirror_b_i(mb),
    .safety_out_a_o(out_a), .safety_out_b_o(out_b), .ready_o(ready), .fault_o(fault));

  button_contactor_model u_far (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .left_press_i(l_press), .right_press_i(r_press),
    .left_nc_i(l_nc), .right_nc_i(r_nc), .left_short_i(l_short), .right_short_i(r_short),
    .loop_open_i(loop_open), .mirror_stuck_i(stuck), .left_button_line_a_i(la),
    .right_button_line_a_i(ra), .safety_out_a_i(out_a), .safety_out_b_i(out_b),
    .left_button_line_b_o(lb), .left_button_line_c_o(lc), .right_button_line_b_o(rb),
    .right_button_line_c_o(rc), .feedback_loop_o(fb), .contactor_mirror_a_o(ma),
    .contactor_mirror_b_o(mb));

  // ============================================================
  // Shared tasks
  task automatic check(input logic seen, input logic exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : cyc

  // Both outputs compared against one expectation, so they must switch as a pair
  task automatic check_out(input logic exp);
    check(out_a, exp);
    check(out_b, exp);
  endtask : check_out

  task automatic do_reset;
    @(negedge mclk_i);
    rst_n_i = 1'b0;
    cyc(10);
    check(out_a, 1'b0);
    check(ready, 1'b0);
    check(la, 1'b0);
    check(ra, 1'b0);
    cyc(10);
    rst_n_i = 1'b1;
    cyc(15);
    check(la, 1'b0);
    cyc(1);
    check(la, 1'b1);
    check(ra, 1'b1);
  endtask : do_reset

  // Bounded wait; lockout plus filtering takes a few test cycles
  task automatic wait_ready;
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 1000)
    begin
      @(negedge mclk_i);
      n++;
    end
    check(ready, 1'b1);
  endtask : wait_ready

  task automatic press(input logic l, input logic r);
    l_press = l;
    r_press = r;
  endtask : press

  // ============================================================
  // Watchdog: the whole sequence needs about 8k cycles
  initial
  begin
    repeat (60000) @(posedge mclk_i);
    error_cnt++;
    give_verdict;
  end

  // ============================================================
  // Main sequence
  initial
  begin
    // Table of strap settings and press timings
    foreach (rows[i])
    begin
      l_nc = rows[i].l_nc;
      r_nc = rows[i].r_nc;
      do_reset;
      wait_ready;
      press(1'b1, 1'b0);
      cyc(rows[i].gap);
      press(1'b1, rows[i].both);
      cyc(200);
      // expected output per row: on for a timely pair, off for a late or lone press
      check_out(rows[i].on);
      press(1'b0, 1'b0);
      cyc(200);
      check_out(1'b0);
      $display("row %0d done", i);
    end

    // Release of one hand drops at once; re-arm needs both released
    l_nc = 1'b0;
    r_nc = 1'b0;
    do_reset;
    wait_ready;
    press(1'b1, 1'b1);
    cyc(200);
    check_out(1'b1);
    check(ready, 1'b0);
    press(1'b0, 1'b1);
    cyc(150);
    check_out(1'b0);
    check(ready, 1'b0);
    press(1'b1, 1'b1);
    cyc(200);
    check_out(1'b0);
    press(1'b0, 1'b0);
    cyc(200);
    wait_ready;
    press(1'b1, 1'b1);
    cyc(200);
    check_out(1'b1);
    press(1'b0, 1'b0);
    cyc(200);
    $display("test release and re-arm done");

    // Open feedback loop blocks arming
    loop_open = 1'b1;
    cyc(50);
    check(ready, 1'b0);
    press(1'b1, 1'b1);
    cyc(200);
    check_out(1'b0);
    press(1'b0, 1'b0);
    loop_open = 1'b0;
    cyc(200);
    wait_ready;
    $display("test feedback loop done");

    // Welded contact while idle must be flagged and latched
    stuck = 1'b1;
    cyc(300);
    check(fault, 1'b1);
    stuck = 1'b0;
    cyc(100);
    press(1'b1, 1'b1);
    cyc(200);
    check_out(1'b0);
    check(fault, 1'b1);
    $display("test contact mismatch done");

    // Buttons held through reset must not start the outputs
    do_reset;
    cyc(300);
    check_out(1'b0);
    check(ready, 1'b0);
    press(1'b0, 1'b0);
    cyc(200);
    wait_ready;
    $display("test power-up lockout done");

    // Shorted control line on each side
    l_short = 1'b1;
    cyc(100);
    check(fault, 1'b1);
    press(1'b1, 1'b1);
    cyc(200);
    check_out(1'b0);
    press(1'b0, 1'b0);
    l_short = 1'b0;
    do_reset;
    wait_ready;
    r_short = 1'b1;
    cyc(100);
    check(fault, 1'b1);
    check(ready, 1'b0);
    r_short = 1'b0;
    $display("test line short done");
    give_verdict;
  end
endmodule : two_hand_control_logic_test
